/* File: core/adcseq_top.sv */
// Conversion sequencer: APB registers, clock dividers, phase sequencing.
// Assumes clock ticks and timer strobe come from logic on pclk; comparator is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module adcseq_top
	import adcseq_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Clock ticks and timer
	input  wire logic        instruction_clock,
	input  wire logic        pwm_timer_clock,
	input  wire logic        ref_clock_first,
	input  wire logic        timer_sample_strobe,
	input  wire logic        pll_mode,
	input  wire logic        freq_select,
	input  wire logic [1:0]  pll_freq_bits,
	// Analog side
	input  wire logic        comparator_above,
	output adcseq_analog_t   analog_ctrl,
	output logic             ref_clock_second,
	output logic             conv_irq_request
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0]    analog_config;   // Analog configuration register
	logic          conv_pending_flag; // Result ready flag
	logic          conv_irq_enable; // Interrupt enable
	logic          conv_start_busy; // Start / busy bit
	logic          reference_select; // Reference select
	logic [3:0]    channel_select;  // Channel select
	logic [7:0]    conv_result;     // Stored result
	logic          az_active;       // Captured autozero enable
	adcseq_state_t state;           // Sequencer state
	logic [4:0]    phase_cnt;       // Cycles within phase
	logic [7:0]    sar_code;        // Trial code
	logic [7:0]    sar_bit;         // Bit under trial
	logic [2:0]    div_cnt;         // Speed divider
	logic [4:0]    tdiv_cnt;        // Timer divider
	logic          ref_half;        // Reference toggle
	logic          strobe_prev;     // Strobe edge memory
	logic          cmp_meta;        // Comparator sync stage one
	logic          cmp_sync;        // Comparator sync stage two
	logic          wr_en;           // Write access phase
	logic          rd_setup;        // Read setup phase
	logic          auto_mode;       // Auto-sample enabled
	logic [1:0]    speed;           // Divide field
	logic [4:0]    tdiv_factor;     // Timer divide factor
	logic          timer_us_tick;   // One-microsecond timer tick
	logic          base_tick;       // Conversion base clock tick
	logic [2:0]    div_mask;        // Speed mask
	logic          conv_tick;       // Conversion clock tick
	logic          sw_trigger;      // Software start
	logic          hw_trigger;      // Strobe start
	logic          set_pending;     // Result stored this cycle
	logic          phase_done;      // Last cycle of phase

	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign auto_mode = analog_config[ADCSEQ_AC_AUTO];
	assign speed = analog_config[ADCSEQ_AC_SPDH:ADCSEQ_AC_SPDL];

	// ************************************************************
	// Clock generation
	// ************************************************************
	// Timer divide factor from PLL settings, prescale ignored
	always_comb begin
		if (pll_mode) begin
			tdiv_factor = freq_select ? (5'h10 >> pll_freq_bits) : (5'h08 >> pll_freq_bits);
		end else begin
			tdiv_factor = freq_select ? 5'h02 : 5'h01;
		end
		if (tdiv_factor == 5'h00) begin
			tdiv_factor = 5'h01;
		end
	end

	// Divide the timer clock to one-microsecond ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdiv_cnt <= 5'h00;
		end else if (pwm_timer_clock) begin
			tdiv_cnt <= (tdiv_cnt >= tdiv_factor - 5'h01) ? 5'h00 : tdiv_cnt + 5'h01;
		end
	end
	assign timer_us_tick = pwm_timer_clock & (tdiv_cnt >= tdiv_factor - 5'h01);

	// Source follows the mode bit
	assign base_tick = auto_mode ? timer_us_tick : instruction_clock;

	// Speed divider; realigned at each trigger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 3'h0;
		end else if (sw_trigger | hw_trigger) begin
			div_cnt <= 3'h0;
		end else if (base_tick) begin
			div_cnt <= div_cnt + 3'h1;
		end
	end
	assign div_mask = 3'(({1'b0, 3'h1} << speed) - 4'h1);
	assign conv_tick = base_tick & ((div_cnt & div_mask) == div_mask);

	// Second reference clock, halved on request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_half <= 1'b0;
			ref_clock_second <= 1'b0;
		end else begin
			if (ref_clock_first) begin
				ref_half <= ~ref_half;
			end
			// Every tick, or every other tick when halved
			ref_clock_second <= ref_clock_first & (~analog_config[ADCSEQ_AC_REFH] | ref_half);
		end
	end

	// ************************************************************
	// Triggers
	// ************************************************************
	// Comparator synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= comparator_above;
			cmp_sync <= cmp_meta;
		end
	end

	// Strobe edge memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_prev <= 1'b0;
		end else begin
			strobe_prev <= timer_sample_strobe;
		end
	end

	// Strobe edges count only in auto mode when idle
	assign hw_trigger = auto_mode & timer_sample_strobe & ~strobe_prev & ~conv_start_busy;
	// Software start only in standard mode when idle
	assign sw_trigger = ~auto_mode & wr_en & (paddr == ADCSEQ_ADDR_CONTROL)
		& pwdata[ADCSEQ_CC_START] & ~conv_start_busy;

	// ************************************************************
	// Registers
	// ************************************************************
	// Analog configuration; clock and mode held while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_config <= ADCSEQ_RST_ANALOG;
		end else if (wr_en && paddr == ADCSEQ_ADDR_ANALOG) begin
			analog_config <= pwdata[7:0];
			if (conv_start_busy) begin
				analog_config[ADCSEQ_AC_AUTO] <= analog_config[ADCSEQ_AC_AUTO];
				analog_config[ADCSEQ_AC_SPDH:ADCSEQ_AC_SPDL] <= speed;
			end
		end
	end

	// Control fields; reference and channel held while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_irq_enable <= ADCSEQ_RST_CONTROL[ADCSEQ_CC_IRQEN];
			reference_select <= ADCSEQ_RST_CONTROL[ADCSEQ_CC_REF];
			channel_select <= ADCSEQ_RST_CONTROL[3:0];
		end else if (wr_en && paddr == ADCSEQ_ADDR_CONTROL) begin
			conv_irq_enable <= pwdata[ADCSEQ_CC_IRQEN];
			if (!conv_start_busy) begin
				reference_select <= pwdata[ADCSEQ_CC_REF];
				channel_select <= pwdata[3:0];
			end
		end
	end

	// Pending flag: set wins, write zero clears, write one holds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_pending_flag <= ADCSEQ_RST_CONTROL[ADCSEQ_CC_PEND];
		end else if (set_pending) begin
			conv_pending_flag <= 1'b1;
		end else if (wr_en && paddr == ADCSEQ_ADDR_CONTROL && !pwdata[ADCSEQ_CC_PEND]) begin
			conv_pending_flag <= 1'b0;
		end
	end
	assign conv_irq_request = conv_pending_flag & conv_irq_enable;

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
			if (paddr == ADCSEQ_ADDR_CONTROL) begin
				if (rd_setup) begin
					prdata[7:0] <= {conv_pending_flag, conv_irq_enable, conv_start_busy,
						reference_select, channel_select};
				end
			end else if (paddr == ADCSEQ_ADDR_ANALOG) begin
				if (rd_setup) begin
					prdata[7:0] <= analog_config;
				end
			end else if (paddr == ADCSEQ_ADDR_RESULT) begin
				if (rd_setup) begin
					prdata[7:0] <= conv_result;
				end
				pslverr <= pwrite; // Result is read-only
			end else begin
				pslverr <= 1'b1; // Unmapped address
			end
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		phase_done = 1'b0;
		case (state)
			ADCSEQ_AZOFF:  phase_done = (phase_cnt == ADCSEQ_AZOFF_CYC - 5'h01);
			ADCSEQ_AZGAIN: phase_done = (phase_cnt == ADCSEQ_AZGAIN_CYC - 5'h01);
			ADCSEQ_SAMPLE: phase_done = (phase_cnt == ADCSEQ_SAMPLE_CYC - 5'h01);
			ADCSEQ_CONV:   phase_done = (phase_cnt == ADCSEQ_CONV_CYC - 5'h01);
			default:       phase_done = 1'b0;
		endcase
	end
	assign set_pending = (state == ADCSEQ_CONV) & conv_tick & phase_done;

	// Phase state, busy bit and captured autozero enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ADCSEQ_IDLE;
			phase_cnt <= 5'h00;
			conv_start_busy <= 1'b0;
			az_active <= 1'b0;
		end else begin
			case (state)
				ADCSEQ_IDLE: begin
					phase_cnt <= 5'h00;
					if (sw_trigger || hw_trigger) begin
						conv_start_busy <= 1'b1;
						az_active <= analog_config[ADCSEQ_AC_AZ];
						if (hw_trigger) begin
							state <= ADCSEQ_DELAY;
						end else if (analog_config[ADCSEQ_AC_AZ]) begin
							state <= ADCSEQ_AZOFF;
						end else begin
							state <= ADCSEQ_SAMPLE;
						end
					end
				end
				ADCSEQ_DELAY: begin
					if (timer_us_tick) begin
						state <= az_active ? ADCSEQ_AZOFF : ADCSEQ_SAMPLE;
					end
				end
				ADCSEQ_AZOFF, ADCSEQ_AZGAIN, ADCSEQ_SAMPLE, ADCSEQ_CONV: begin
					if (conv_tick) begin
						phase_cnt <= phase_done ? 5'h00 : phase_cnt + 5'h01;
						if (phase_done) begin
							// Autozero runs 6+5+9, standard 4+9
							case (state)
								ADCSEQ_AZOFF:  state <= ADCSEQ_AZGAIN;
								ADCSEQ_AZGAIN: state <= ADCSEQ_CONV;
								ADCSEQ_SAMPLE: state <= ADCSEQ_CONV;
								default:       state <= ADCSEQ_FINISH;
							endcase
						end
					end
				end
				ADCSEQ_FINISH: begin
					// Busy falls on an instruction tick, after the flag
					if (instruction_clock) begin
						conv_start_busy <= 1'b0;
						state <= ADCSEQ_IDLE;
					end
				end
				default: begin
					state <= ADCSEQ_IDLE;
				end
			endcase
		end
	end

	// Successive approximation over eight cycles, store on ninth
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sar_code <= 8'h00;
			sar_bit <= 8'h00;
			conv_result <= 8'h00;
		end else if (state != ADCSEQ_CONV) begin
			sar_code <= ADCSEQ_SAR_FIRST;
			sar_bit <= ADCSEQ_SAR_FIRST;
		end else if (conv_tick) begin
			if (phase_done) begin
				conv_result <= sar_code;
			end else if (sar_bit != 8'h00) begin
				// Keep the trial bit only while input is above
				sar_code <= (cmp_sync ? sar_code : (sar_code & ~sar_bit)) | (sar_bit >> 1);
				sar_bit <= sar_bit >> 1;
			end
		end
	end

	// ************************************************************
	// Analog controls
	// ************************************************************
	always_comb begin
		analog_ctrl.comparator_to_g2 = analog_config[ADCSEQ_AC_CMPS];
		analog_ctrl.spare_amp_enable = analog_config[ADCSEQ_AC_AMP];
		analog_ctrl.current_source_enable = analog_config[ADCSEQ_AC_ISRC];
		// Captured value while busy, register value otherwise
		analog_ctrl.autozero_enable = conv_start_busy ? az_active : analog_config[ADCSEQ_AC_AZ];
		analog_ctrl.reference_select = reference_select;
		analog_ctrl.channel_select = channel_select;
		analog_ctrl.sample_hold = (state == ADCSEQ_SAMPLE);
		analog_ctrl.autozero_offset = (state == ADCSEQ_AZOFF);
		analog_ctrl.autozero_gain = (state == ADCSEQ_AZGAIN);
		analog_ctrl.resolving = (state == ADCSEQ_CONV);
		analog_ctrl.sar_code = sar_code;
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	logic [4:0] chk_ticks; // Conversion ticks since first phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_ticks <= 5'h00;
		end else if (state == ADCSEQ_IDLE || state == ADCSEQ_DELAY) begin
			chk_ticks <= 5'h00;
		end else if (conv_tick && state != ADCSEQ_FINISH) begin
			chk_ticks <= chk_ticks + 5'h01;
		end
	end
	sequence s_store;
		set_pending;
	endsequence
	sequence s_finish_then_idle;
		(state == ADCSEQ_FINISH) ##1 1'b1;
	endsequence

	AST_STD_LEN: assert property (@(posedge pclk) disable iff (!presetn)
		(s_store and !az_active) |-> chk_ticks == ADCSEQ_STD_TOTAL - 5'h01)
		else $error("standard conversion length wrong");
	AST_AZ_LEN: assert property (@(posedge pclk) disable iff (!presetn)
		(s_store and az_active) |-> chk_ticks == ADCSEQ_AZ_TOTAL - 5'h01)
		else $error("autozero conversion length wrong");
	AST_PEND_SET: assert property (@(posedge pclk) disable iff (!presetn)
		s_store |=> conv_pending_flag && conv_start_busy && conv_result == $past(sar_code))
		else $error("pending or result not set at store");
	AST_BUSY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(conv_start_busy) |-> $past(state) == ADCSEQ_FINISH)
		else $error("start bit cleared before completion");
	AST_START: assert property (@(posedge pclk) disable iff (!presetn)
		sw_trigger |=> conv_start_busy && state != ADCSEQ_IDLE)
		else $error("software start did not begin");
	AST_STROBE_IGN: assert property (@(posedge pclk) disable iff (!presetn)
		conv_start_busy |-> !hw_trigger)
		else $error("strobe accepted while busy");
	AST_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		hw_trigger |=> state == ADCSEQ_DELAY && conv_start_busy)
		else $error("auto trigger skipped delay");
	AST_PEND_W1: assert property (@(posedge pclk) disable iff (!presetn)
		!conv_pending_flag && !set_pending |=> !conv_pending_flag)
		else $error("pending set without a result");
	AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		conv_irq_request == (conv_pending_flag && conv_irq_enable))
		else $error("interrupt request mismatch");
	AST_AZ_HELD: assert property (@(posedge pclk) disable iff (!presetn)
		conv_start_busy && $past(conv_start_busy) |-> $stable(analog_ctrl.autozero_enable))
		else $error("autozero enable changed mid conversion");
	AST_FIN: assert property (@(posedge pclk) disable iff (!presetn)
		s_finish_then_idle |-> conv_pending_flag || conv_start_busy || $past(instruction_clock))
		else $error("finish state misbehaved");
endmodule : adcseq_top
`default_nettype wire

/* File: shared/adcseq_pkg.sv */
// Constants, register map and carrier types for the conversion sequencer.
// Assumes one 10 MHz clock; byte address of a register is four times its index.
package adcseq_pkg;
	// ************************************************************
	// Register indices and byte addresses
	// ************************************************************
	localparam logic [9:0] ADCSEQ_IDX_CONTROL = 10'h09f; // Converter control index
	localparam logic [9:0] ADCSEQ_IDX_ANALOG  = 10'h0a0; // Analog configuration index
	localparam logic [9:0] ADCSEQ_IDX_RESULT  = 10'h0a1; // Result register index
	localparam logic [11:0] ADCSEQ_ADDR_CONTROL = {ADCSEQ_IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADCSEQ_ADDR_ANALOG  = {ADCSEQ_IDX_ANALOG, 2'h0};
	localparam logic [11:0] ADCSEQ_ADDR_RESULT  = {ADCSEQ_IDX_RESULT, 2'h0};
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int ADCSEQ_CC_PEND  = 7; // Pending flag
	localparam int ADCSEQ_CC_IRQEN = 6; // Interrupt enable
	localparam int ADCSEQ_CC_START = 5; // Start / busy
	localparam int ADCSEQ_CC_REF   = 4; // Reference select
	localparam int ADCSEQ_AC_REFH  = 7; // Reference clock halve
	localparam int ADCSEQ_AC_CMPS  = 6; // Comparator input select
	localparam int ADCSEQ_AC_AMP   = 5; // Spare amplifier enable
	localparam int ADCSEQ_AC_AUTO  = 4; // Auto-sample enable
	localparam int ADCSEQ_AC_SPDH  = 3; // Divide field high bit
	localparam int ADCSEQ_AC_SPDL  = 2; // Divide field low bit
	localparam int ADCSEQ_AC_ISRC  = 1; // Current source enable
	localparam int ADCSEQ_AC_AZ    = 0; // Autozero enable
	localparam logic [7:0] ADCSEQ_RST_CONTROL = 8'h00;
	localparam logic [7:0] ADCSEQ_RST_ANALOG  = 8'h00;
	// ************************************************************
	// Phase lengths in conversion clock cycles
	// ************************************************************
	localparam logic [4:0] ADCSEQ_SAMPLE_CYC = 5'h04;
	localparam logic [4:0] ADCSEQ_CONV_CYC   = 5'h09;
	localparam logic [4:0] ADCSEQ_AZOFF_CYC  = 5'h06;
	localparam logic [4:0] ADCSEQ_AZGAIN_CYC = 5'h05;
	localparam logic [4:0] ADCSEQ_STD_TOTAL  = 5'h0d;
	localparam logic [4:0] ADCSEQ_AZ_TOTAL   = 5'h14;
	localparam logic [7:0] ADCSEQ_SAR_FIRST  = 8'h80; // First trial bit
	// ************************************************************
	// Sequencer states and analog carrier
	// ************************************************************
	typedef enum logic [6:0] {
		ADCSEQ_IDLE   = 7'h01,
		ADCSEQ_DELAY  = 7'h02,
		ADCSEQ_AZOFF  = 7'h04,
		ADCSEQ_AZGAIN = 7'h08,
		ADCSEQ_SAMPLE = 7'h10,
		ADCSEQ_CONV   = 7'h20,
		ADCSEQ_FINISH = 7'h40
	} adcseq_state_t;
	typedef struct packed {
		logic       comparator_to_g2;      // Comparator input from G2
		logic       spare_amp_enable;      // Spare amplifier on
		logic       current_source_enable; // Current source on
		logic       autozero_enable;       // Autozero amplifier on
		logic       reference_select;      // Supply as reference
		logic [3:0] channel_select;        // Analog mux channel
		logic       sample_hold;           // Sample phase active
		logic       autozero_offset;       // Offset phase active
		logic       autozero_gain;         // Gain phase active
		logic       resolving;             // Successive approximation
		logic [7:0] sar_code;              // Trial code to the DAC
	} adcseq_analog_t;
endpackage : adcseq_pkg

/* File: verif/adc_conversion_sequencer_test.sv */
// Testbench: APB tasks and conversion scenarios for the sequencer.
// Assumes the far-side model supplies ticks, strobe and comparator.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_test;
	import adcseq_pkg::*;
	logic           pclk, presetn, psel, penable, pwrite, fire, arm, err;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata, rd;
	logic           pready, pslverr, itk, ttk, rtk, stb, cmp, rck2, irq;
	logic           pll_mode, freq_select;
	logic [1:0]     pll_freq_bits;
	logic [7:0]     level;
	adcseq_analog_t actl;
	int             mismatches, n_tests, cyc, t0, a, b;
	adcseq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instruction_clock(itk), .pwm_timer_clock(ttk), .ref_clock_first(rtk),
		.timer_sample_strobe(stb), .pll_mode(pll_mode), .freq_select(freq_select),
		.pll_freq_bits(pll_freq_bits), .comparator_above(cmp), .analog_ctrl(actl),
		.ref_clock_second(rck2), .conv_irq_request(irq));
	adcseq_far_model far (.pclk(pclk), .presetn(presetn), .fire(fire), .level(level),
		.sar_code(actl.sar_code), .icl_tick(itk), .tmr_tick(ttk), .ref_tick(rtk),
		.strobe(stb), .cmp_above(cmp));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Cycle count; two strobe pulses, the second while busy
	always @(posedge pclk) begin
		cyc  <= cyc + 1;
		fire <= arm && ((cyc - t0) < 3 || ((cyc - t0) > 12 && (cyc - t0) < 20));
	end
	// Compare and count
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer, then an idle cycle
	task automatic apb(logic wr, logic [11:0] ad, logic [31:0] wd);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= ad;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// One conversion: configure, trigger, time it, read back
	task automatic run(logic auto, logic [7:0] cfg, int ticks, int t, logic [7:0] v);
		level <= v;
		apb(1'b1, ADCSEQ_ADDR_ANALOG, {24'h0, cfg});
		if (auto) begin
			apb(1'b1, ADCSEQ_ADDR_CONTROL, 32'h60);
			apb(1'b0, ADCSEQ_ADDR_CONTROL, 32'h0);
			chk("sw start in auto", 32'h0, {31'h0, rd[5]});
		end
		t0 = cyc;
		arm <= auto;
		if (!auto) apb(1'b1, ADCSEQ_ADDR_CONTROL, 32'h60);
		else repeat (3) @(posedge pclk);
		apb(1'b0, ADCSEQ_ADDR_CONTROL, 32'h0);
		chk("busy", 32'h1, {31'h0, rd[5]});
		if (cfg[0]) begin
			apb(1'b1, ADCSEQ_ADDR_ANALOG, {24'h0, cfg & 8'hfe});
			chk("az held", 32'h1, {31'h0, actl.autozero_enable});
		end
		a = 0;
		// Count resolve-phase cycles while waiting for the result
		while (irq !== 1'b1 && cyc - t0 < 600) begin
			@(posedge pclk);
			a += actl.resolving;
		end
		b = cyc - t0;
		chk("resolve cycles", 9 * t, a);
		chk("length", 32'h1, {31'h0, b > (ticks - 1) * t && b <= ticks * t + 2 * t + 4});
		repeat (50) begin
			apb(1'b0, ADCSEQ_ADDR_CONTROL, 32'h0);
			if (rd[5] === 1'b0) break;
		end
		chk("pending", 32'h1, {31'h0, rd[7]});
		apb(1'b0, ADCSEQ_ADDR_RESULT, 32'h0);
		chk("result", {24'h0, v}, rd);
		apb(1'b1, ADCSEQ_ADDR_CONTROL, 32'h80);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, ADCSEQ_ADDR_CONTROL, 32'hc0);
		chk("pending held", 32'h1, {31'h0, irq});
		apb(1'b1, ADCSEQ_ADDR_CONTROL, 32'h40);
		apb(1'b0, ADCSEQ_ADDR_CONTROL, 32'h0);
		chk("pending cleared", 32'h40, rd);
		chk("az idle", 32'h0, {31'h0, actl.autozero_enable});
		arm <= 1'b0;
	endtask : run
	// Verdict and end of run
	task automatic summarize();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		summarize();
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		arm = 1'b0;
		level = 8'h00;
		pll_mode = 1'b0;
		freq_select = 1'b0;
		pll_freq_bits = 2'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADCSEQ_ADDR_ANALOG, 32'h0);
		chk("analog reset", {24'h0, ADCSEQ_RST_ANALOG}, rd);
		apb(1'b0, ADCSEQ_ADDR_CONTROL, 32'h0);
		chk("control reset", {24'h0, ADCSEQ_RST_CONTROL}, rd);
		apb(1'b0, 12'h000, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, ADCSEQ_ADDR_RESULT, 32'h5);
		chk("result write", 32'h1, {31'h0, err});
		apb(1'b1, ADCSEQ_ADDR_ANALOG, 32'h62);
		chk("pins", 32'h7, {29'h0, actl.comparator_to_g2, actl.spare_amp_enable,
			actl.current_source_enable});
		for (int h = 0; h < 2; h++) begin
			apb(1'b1, ADCSEQ_ADDR_ANALOG, h ? 32'h80 : 32'h00);
			a = 0;
			b = 0;
			repeat (48) begin
				@(posedge pclk);
				a += rtk;
				b += rck2;
			end
			chk("ref halve", a >> h, b);
		end
		apb(1'b1, ADCSEQ_ADDR_CONTROL, 32'h5a);
		chk("ref chan", 32'h1a, {27'h0, actl.reference_select, actl.channel_select});
		for (int d = 0; d < 4; d++)
			run(1'b0, 8'(d << 2), 13, 4 << d, 8'(37 * d + 90));
		run(1'b0, 8'h01, 20, 4, 8'hc3);
		run(1'b1, 8'h10, 14, 3, 8'h3c);
		pll_mode <= 1'b1;
		pll_freq_bits <= 2'h2;
		run(1'b1, 8'h10, 14, 6, 8'hff);
		summarize();
	end
endmodule : adc_conversion_sequencer_test
`default_nettype wire

/* File: verif/adcseq_far_model.sv */
// Far-side model: clock ticks, timer strobe and comparator.
// Assumes one pclk domain; every tick lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module adcseq_far_model (
	// Clock, reset, stimulus
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       fire,
	input  wire logic [7:0] level,
	input  wire logic [7:0] sar_code,
	// Ticks, strobe, comparator
	output logic            icl_tick,
	output logic            tmr_tick,
	output logic            ref_tick,
	output logic            strobe,
	output logic            cmp_above
);
	logic [3:0] cnt; // Tick phase, wraps at twelve
	// Phase counter; strobe follows the bench request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt    <= 4'h0;
			strobe <= 1'b0;
		end else begin
			cnt    <= (cnt == 4'hb) ? 4'h0 : cnt + 4'h1;
			strobe <= fire;
		end
	end
	// Every 3 or 4 cycles: leaves the comparator synchroniser time to settle
	assign icl_tick = cnt[1:0] == 2'h1;     // Every 4 cycles
	assign tmr_tick = (cnt % 4'h3) == 4'h0; // Every 3 cycles
	assign ref_tick = cnt[1:0] == 2'h3;     // Every 4 cycles
	// Input sits half a code above level, so either trial rule lands on level
	assign cmp_above = {sar_code, 1'b0} < {level, 1'b1};
endmodule : adcseq_far_model
`default_nettype wire
